// *** rtl/async_serial_receiver.sv ***
// Asynchronous serial receiver with two-character buffer and registers.
`default_nettype none
`include "rx_map.svh"
module async_serial_receiver (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [`RX_AW-1:0]    addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   input  wire logic                 rx_i,
   output logic [7:0]                rdata_o,
   output logic                      irq_o
);
   import rx_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]  ctrl;
   logic [15:0] divisor;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic        overrun;
   rx_char_t    buf_mem [0:1];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  count;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [`RX_AW-1:0] a,
                                input logic [`RX_AW-1:0] off);
      return a == off;
   endfunction

   wire wr_ctrl  = wr_i && hit(addr_i, `RX_OFF_CTRL);
   wire wr_div_l = wr_i && hit(addr_i, `RX_OFF_DIV_LO);
   wire wr_div_h = wr_i && hit(addr_i, `RX_OFF_DIV_HI);
   wire wr_istat = wr_i && hit(addr_i, `RX_OFF_IRQ_STAT);
   wire wr_imask = wr_i && hit(addr_i, `RX_OFF_IRQ_MASK);
   wire rd_data  = rd_i && hit(addr_i, `RX_OFF_DATA);
   wire rd_stat  = rd_i && hit(addr_i, `RX_OFF_STATUS);

   wire port_enable               = ctrl[`RX_CTRL_PEN];
   wire sync_select               = ctrl[`RX_CTRL_SYNC];
   wire continuous_receive_enable = ctrl[`RX_CTRL_CONTINUOUS_RECEIVE_ENABLE];
   wire nine_bit_receive_select   = ctrl[`RX_CTRL_NINE];
   wire address_detect_enable     = ctrl[`RX_CTRL_ADDRESS_DETECT_ENABLE];
   wire high_speed_baud_select    = ctrl[`RX_CTRL_HSPEED];
   wire wide_divisor_select       = ctrl[`RX_CTRL_WIDE];

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   // Reception also halts while an overrun stands; it is recovered only
   // by toggling continuous receive, so no later character is mixed in.
   wire rx_active = port_enable && !sync_select && continuous_receive_enable
                    && !overrun;
   wire addr_mode = address_detect_enable && nine_bit_receive_select;

   wire       tick;
   wire       done;
   rx_char_t  chr;
   wire       receiver_idle_indicator;
   wire [3:0] os_max = high_speed_baud_select ? `RX_OS_HIGH : `RX_OS_LOW;

   baud_tick u_baud (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (rx_active),
      .wide_i  (wide_divisor_select),
      .div_i   (divisor),
      .tick_o  (tick)
   );

   rx_shifter u_shift (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .en_i     (rx_active),
      .tick_i   (tick),
      .os_max_i (os_max),
      .nine_i   (nine_bit_receive_select),
      .rx_i     (rx_i),
      .done_o   (done),
      .chr_o    (chr),
      .idle_o   (receiver_idle_indicator)
   );

   // ----------------------------------------------------------------
   // Receive buffer
   // ----------------------------------------------------------------
   wire      receive_ready_flag = count != 2'h0;
   wire      pop    = rd_data && receive_ready_flag;
   wire      accept = done && rx_active
                      && (!addr_mode || chr.ninth);
   wire      full   = count == `RX_BUF_DEPTH && !pop;
   wire      push   = accept && !full;
   wire      ovr_ev = accept && full;
   wire rx_char_t head = buf_mem[rd_ptr];

   wire [1:0] next_count = count + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) wr_ptr <= !wr_ptr;
         if (pop) rd_ptr <= !rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) buf_mem[wr_ptr] <= chr;
   end

   // ----------------------------------------------------------------
   // Control and status registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl    <= `RX_CTRL_RST;
         divisor <= `RX_DIV_RST;
      end else begin
         if (wr_ctrl) ctrl <= wdata_i;
         if (wr_div_l) divisor[7:0] <= wdata_i;
         if (wr_div_h) divisor[15:8] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) overrun <= 1'b0;
      else if (ovr_ev) overrun <= 1'b1;
      else if (!continuous_receive_enable) overrun <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   wire [2:0] irq_ev = {done && rx_active && chr.ferr, ovr_ev, push};
   wire [2:0] irq_clr = wr_istat ? wdata_i[2:0] : 3'h0;
   wire [2:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat <= `RX_IRQ_RST;
         irq_mask <= `RX_IRQ_RST;
         irq_o    <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (wr_imask) irq_mask <= wdata_i[2:0];
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   wire ninth_rd = receive_ready_flag && nine_bit_receive_select
                   && (head.ninth || addr_mode);
   wire [7:0] status_rd = {3'h0, receive_ready_flag, receiver_idle_indicator,
                           overrun, receive_ready_flag && head.ferr,
                           ninth_rd};
   wire [7:0] data_rd = receive_ready_flag ? head.data : 8'h00;

   logic [7:0] rd_mux;
   always_comb begin
      case (addr_i)
         `RX_OFF_CTRL:     rd_mux = ctrl;
         `RX_OFF_DIV_LO:   rd_mux = divisor[7:0];
         `RX_OFF_DIV_HI:   rd_mux = divisor[15:8];
         `RX_OFF_STATUS:   rd_mux = status_rd;
         `RX_OFF_DATA:     rd_mux = data_rd;
         `RX_OFF_IRQ_STAT: rd_mux = {5'h00, irq_stat};
         `RX_OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask};
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rdata_o <= 8'h00;
      else rdata_o <= rd_i ? rd_mux : 8'h00;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_push;
      push && !pop;
   endsequence

   sequence s_ready_after;
      ##1 receive_ready_flag;
   endsequence

   property p_ready_set;
      @(posedge clk_i) disable iff (!rst_n_i) s_push |-> s_ready_after;
   endproperty
   a_ready_set: assert property (p_ready_set)
      else $error("ready flag not set after transfer");

   property p_irq_gate;
      @(posedge clk_i) disable iff (!rst_n_i)
         push && !irq_mask[`RX_IRQ_RX] && irq_stat[2:1] == 2'h0 && !wr_imask
         && !irq_ev[`RX_IRQ_FERR]
         |=> ##1 !irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt raised while disabled");

   property p_irq_raise;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_push ##1 (irq_mask[`RX_IRQ_RX] && !wr_istat) |=> irq_o;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("enabled interrupt not raised");

   property p_ninth_off;
      @(posedge clk_i) disable iff (!rst_n_i)
         rd_stat && !nine_bit_receive_select |=> !rdata_o[`RX_ST_NINTH];
   endproperty
   a_ninth_off: assert property (p_ninth_off)
      else $error("ninth bit shown in eight-bit mode");

   property p_data_read;
      @(posedge clk_i) disable iff (!rst_n_i)
         pop |=> rdata_o == $past(head.data);
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read does not match buffer head");

   property p_overrun_error_flag_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
         !continuous_receive_enable && !ovr_ev |=> !overrun;
   endproperty
   a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear)
      else $error("overrun not cleared by receive disable");

   property p_addr_drop;
      @(posedge clk_i) disable iff (!rst_n_i)
         done && addr_mode && !chr.ninth && !pop |=> $stable(count);
   endproperty
   a_addr_drop: assert property (p_addr_drop)
      else $error("address mode kept a data character");

   property p_addr_ninth;
      @(posedge clk_i) disable iff (!rst_n_i)
         rd_stat && addr_mode && receive_ready_flag |=> rdata_o[`RX_ST_NINTH];
   endproperty
   a_addr_ninth: assert property (p_addr_ninth)
      else $error("address mode ninth bit not one");

   property p_overrun;
      @(posedge clk_i) disable iff (!rst_n_i)
         accept && count == `RX_BUF_DEPTH && !pop && !wr_ctrl
         |=> overrun ##1 overrun;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("third character did not set overrun");

   property p_drain;
      @(posedge clk_i) disable iff (!rst_n_i)
         pop && count == 2'h1 && !push |=> !receive_ready_flag;
   endproperty
   a_drain: assert property (p_drain)
      else $error("ready flag stuck after last read");

   property p_disabled;
      @(posedge clk_i) disable iff (!rst_n_i)
         !continuous_receive_enable && !pop |=> $stable(count);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("character taken while receive disabled");
endmodule // async_serial_receiver
`default_nettype wire

// *** include/rx_map.svh ***
// Register offsets, field positions and reset values of the serial receiver.
`ifndef RX_MAP_SVH
`define RX_MAP_SVH
`define RX_AW           3
`define RX_OFF_CTRL     3'h0
`define RX_OFF_DIV_LO   3'h1
`define RX_OFF_DIV_HI   3'h2
`define RX_OFF_STATUS   3'h3
`define RX_OFF_DATA     3'h4
`define RX_OFF_IRQ_STAT 3'h5
`define RX_OFF_IRQ_MASK 3'h6
`define RX_CTRL_PEN     0
`define RX_CTRL_SYNC    1
`define RX_CTRL_CONTINUOUS_RECEIVE_ENABLE    2
`define RX_CTRL_NINE    3
`define RX_CTRL_ADDRESS_DETECT_ENABLE   4
`define RX_CTRL_HSPEED  5
`define RX_CTRL_WIDE    6
`define RX_ST_NINTH     0
`define RX_ST_FERR      1
`define RX_ST_OVERRUN_ERROR_FLAG      2
`define RX_ST_IDLE      3
`define RX_ST_READY     4
`define RX_IRQ_RX       0
`define RX_IRQ_OVR      1
`define RX_IRQ_FERR     2
`define RX_CTRL_RST     8'h00
`define RX_DIV_RST      16'h0000
`define RX_IRQ_RST      3'h0
`define RX_OS_LOW       4'hf
`define RX_OS_HIGH      4'h3
`define RX_BUF_DEPTH    2'h2
`endif

// *** include/rx_pkg.sv ***
// Types shared by the serial receiver modules.
`default_nettype none
package rx_pkg;
   typedef struct packed {
      logic       ferr;
      logic       ninth;
      logic [7:0] data;
   } rx_char_t;
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_t;
endpackage
`default_nettype wire

// *** rtl/baud_tick.sv ***
// Oversampling tick generator driven by the baud divisor.
`default_nettype none
`include "rx_map.svh"
module baud_tick (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        run_i,
   input  wire logic        wide_i,
   input  wire logic [15:0] div_i,
   output logic             tick_o
);
   logic [15:0] cnt;
   wire  [15:0] top = wide_i ? div_i : {8'h00, div_i[7:0]};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt    <= `RX_DIV_RST;
         tick_o <= 1'b0;
      end else if (!run_i || cnt >= top) begin
         cnt    <= `RX_DIV_RST;
         tick_o <= run_i;
      end else begin
         cnt    <= cnt + 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule // baud_tick
`default_nettype wire

// *** rtl/rx_shifter.sv ***
// Frame receiver: start, eight or nine data bits, stop.
`default_nettype none
`include "rx_map.svh"
module rx_shifter (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             en_i,
   input  wire logic             tick_i,
   input  wire logic [3:0]       os_max_i,
   input  wire logic             nine_i,
   input  wire logic             rx_i,
   output logic                  done_o,
   output rx_pkg::rx_char_t      chr_o,
   output logic                  idle_o
);
   import rx_pkg::*;
   rx_state_t  state;
   logic [3:0] cnt;
   logic [3:0] bitn;
   logic [8:0] sr;
   wire        at_end  = tick_i && cnt == os_max_i;
   wire        at_half = tick_i && cnt == {1'b0, os_max_i[3:1]};
   wire [3:0]  last    = nine_i ? 4'h8 : 4'h7;

   assign idle_o = state == ST_IDLE;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state  <= ST_IDLE;
         cnt    <= 4'h0;
         bitn   <= 4'h0;
         sr     <= 9'h000;
         done_o <= 1'b0;
         chr_o  <= '0;
      end else begin
         done_o <= 1'b0;
         if (tick_i) cnt <= at_end ? 4'h0 : cnt + 4'h1;
         case (state)
            ST_IDLE: begin
               cnt <= 4'h0;
               if (en_i && !rx_i) state <= ST_START;
            end
            ST_START: if (at_half) begin
               cnt   <= 4'h0;
               bitn  <= 4'h0;
               state <= rx_i ? ST_IDLE : ST_DATA;
            end
            ST_DATA: if (at_end) begin
               sr   <= {rx_i, sr[8:1]};
               bitn <= bitn + 4'h1;
               if (bitn == last) state <= ST_STOP;
            end
            ST_STOP: if (at_end) begin
               state       <= ST_IDLE;
               done_o      <= 1'b1;
               chr_o.ferr  <= !rx_i;
               chr_o.ninth <= nine_i & sr[8];
               chr_o.data  <= nine_i ? sr[7:0] : sr[8:1];
            end
            default: state <= ST_IDLE;
         endcase
         if (!en_i) state <= ST_IDLE;
      end
   end
endmodule // rx_shifter
`default_nettype wire

// *** bench/serial_tx_model.sv ***
// Remote serial transmitter model that drives the receive line.
`default_nettype none
module serial_tx_model #(
   parameter int BIT_CLKS = 8
) (
   input  wire logic clk_i,
   output logic      line_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // Frame sender
   // ---------------------------------------------------------------
   // The line rests high between frames, so every start bit is a falling edge.
   initial line_o = 1'b1;

   // Clocks a bit; the bench changes it only while the line rests.
   int bit_clks = BIT_CLKS;

   // A zero gap sends frames back to back; a larger gap models a slow sender.
   task automatic send(input logic [8:0] d, input logic nine, input int gap);
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (bit_clks) @(posedge clk_i);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         line_o <= d[i];
         repeat (bit_clks) @(posedge clk_i);
      end
      line_o <= 1'b1;
      repeat (bit_clks + gap) @(posedge clk_i);
   endtask
endmodule // serial_tx_model
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking testbench of the asynchronous serial receiver.
`default_nettype none
`include "rx_map.svh"
`define CHECK_EQ(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   // Divisor low byte 1 and four ticks a bit in fast mode give eight clocks a bit.
   localparam int         BIT_CLKS = 8;
   // Sixteen ticks a bit at two clocks a tick give thirty-two clocks a bit.
   localparam int         SLOW_BIT_CLKS = 32;
   localparam logic [7:0] PEN      = 8'h01 << `RX_CTRL_PEN;
   localparam logic [7:0] SYNC     = 8'h01 << `RX_CTRL_SYNC;
   localparam logic [7:0] CONTINUOUS_RECEIVE_ENABLE     = 8'h01 << `RX_CTRL_CONTINUOUS_RECEIVE_ENABLE;
   localparam logic [7:0] NINE     = 8'h01 << `RX_CTRL_NINE;
   localparam logic [7:0] ADDRESS_DETECT_ENABLE    = 8'h01 << `RX_CTRL_ADDRESS_DETECT_ENABLE;
   localparam logic [7:0] HS       = 8'h01 << `RX_CTRL_HSPEED;
   localparam logic [7:0] ON       = PEN | CONTINUOUS_RECEIVE_ENABLE | HS;
   localparam logic [7:0] OWN_ADDR = 8'h22;

   logic              clk_i;
   logic              rst_n_i;
   logic [`RX_AW-1:0] addr_i;
   logic [7:0]        wdata_i;
   logic              wr_i;
   logic              rd_i;
   logic              rx_i;
   logic [7:0]        rdata_o;
   logic              irq_o;
   logic [7:0]        rv;
   int                errors;
   int                compares;
   logic [7:0]        off_ctrl [3];

   async_serial_receiver i_dut (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .addr_i  (addr_i),
      .wdata_i (wdata_i),
      .wr_i    (wr_i),
      .rd_i    (rd_i),
      .rx_i    (rx_i),
      .rdata_o (rdata_o),
      .irq_o   (irq_o)
   );

   serial_tx_model #(.BIT_CLKS(BIT_CLKS)) i_tx (
      .clk_i  (clk_i),
      .line_o (rx_i)
   );

   initial clk_i = 1'b0;
   always #25 clk_i = ~clk_i;

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [`RX_AW-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample them there.
   task automatic rd(input logic [`RX_AW-1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic rd_chk(input logic [`RX_AW-1:0] a, input logic [7:0] m, input logic [7:0] e);
      rd(a, rv);
      `CHECK_EQ(rv & m, e)
   endtask

   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk_i);
      #1 `CHECK_EQ(irq_o, e)
   endtask

   task automatic tally_and_finish;
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      errors   = 0;
      compares = 0;
      rst_n_i  = 1'b0;
      wr_i     = 1'b0;
      rd_i     = 1'b0;
      addr_i   = '0;
      wdata_i  = 8'h00;
      off_ctrl = '{CONTINUOUS_RECEIVE_ENABLE | HS, PEN | SYNC | CONTINUOUS_RECEIVE_ENABLE | HS, PEN | HS};
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rd_chk(3'(a), 8'hff, (a == `RX_OFF_STATUS) ? 8'h08 : 8'h00);
      end
      wr(`RX_OFF_DIV_LO, 8'h01);
      rd_chk(`RX_OFF_DIV_LO, 8'hff, 8'h01);
      foreach (off_ctrl[k]) begin
         wr(`RX_OFF_CTRL, off_ctrl[k]);
         i_tx.send(9'h0a5, 1'b0, 4);
         rd_chk(`RX_OFF_STATUS, 8'h10, 8'h00);
      end
      wr(`RX_OFF_CTRL, ON);
      i_tx.send(9'h0a5, 1'b0, 4);
      rd_chk(`RX_OFF_STATUS, 8'h17, 8'h10);
      rd_chk(`RX_OFF_IRQ_STAT, 8'h07, 8'h01);
      `CHECK_EQ(irq_o, 1'b0)
      wr(`RX_OFF_IRQ_MASK, 8'h01);
      irq_chk(1'b1);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'ha5);
      rd_chk(`RX_OFF_STATUS, 8'h10, 8'h00);
      wr(`RX_OFF_IRQ_STAT, 8'h01);
      irq_chk(1'b0);
      wr(`RX_OFF_CTRL, ON | NINE);
      i_tx.send(9'h13c, 1'b1, 4);
      rd_chk(`RX_OFF_STATUS, 8'h17, 8'h11);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h3c);
      i_tx.send(9'h0c3, 1'b1, 4);
      rd_chk(`RX_OFF_STATUS, 8'h17, 8'h10);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'hc3);
      wr(`RX_OFF_CTRL, ON | NINE | ADDRESS_DETECT_ENABLE);
      i_tx.send(9'h011, 1'b1, 4);
      rd_chk(`RX_OFF_STATUS, 8'h10, 8'h00);
      i_tx.send(9'h122, 1'b1, 4);
      rd_chk(`RX_OFF_STATUS, 8'h17, 8'h11);
      rd(`RX_OFF_DATA, rv);
      `CHECK_EQ(rv, OWN_ADDR)
      // Matching the node address is up to software; the receiver keeps no own address.
      if (rv == OWN_ADDR) begin
         wr(`RX_OFF_CTRL, ON | NINE);
      end
      i_tx.send(9'h033, 1'b1, 4);
      rd_chk(`RX_OFF_STATUS, 8'h17, 8'h10);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h33);
      wr(`RX_OFF_CTRL, ON);
      for (int i = 0; i < 3; i++) begin
         i_tx.send(9'h040 + 9'(i), 1'b0, 0);
      end
      rd_chk(`RX_OFF_STATUS, 8'h14, 8'h14);
      rd_chk(`RX_OFF_IRQ_STAT, 8'h02, 8'h02);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h40);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h41);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h00);
      wr(`RX_OFF_CTRL, PEN | HS);
      rd_chk(`RX_OFF_STATUS, 8'h04, 8'h00);
      wr(`RX_OFF_CTRL, ON);
      i_tx.send(9'h05a, 1'b0, 4);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h5a);
      // Without the wide select the high divisor byte must not slow the bit rate.
      wr(`RX_OFF_DIV_HI, 8'h01);
      rd_chk(`RX_OFF_DIV_HI, 8'hff, 8'h01);
      wr(`RX_OFF_CTRL, PEN | CONTINUOUS_RECEIVE_ENABLE);
      i_tx.bit_clks = SLOW_BIT_CLKS;
      i_tx.send(9'h096, 1'b0, 4);
      rd_chk(`RX_OFF_STATUS, 8'h17, 8'h10);
      rd_chk(`RX_OFF_DATA, 8'hff, 8'h96);
      tally_and_finish();
   end

   // A hang counts as a mismatch; the tests need well under half this span.
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
